// [hdl/stl_loader.sv]
`default_nettype none
module stl_loader (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        lowPowerRestart,
  output logic             flashRdReq,
  output logic      [23:0] flashAddr,
  input  wire logic        flashRdAck,
  input  wire logic [7:0]  flashRdData,
  output logic             trimWrEn,
  output logic      [7:0]  trimWrAddr,
  output logic      [7:0]  trimWrData,
  output logic      [12:0] slowOscTrimField,
  output logic             oscTrimValid,
  output logic             trimDone,
  output logic             gainDone,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic      [1:0]  bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp
);
  stl_pkg::stl_state_t s;
  stl_pkg::stl_state_t n;
  logic                restartAny;
  logic                swRestart;
  logic                selValid;
  logic [3:0]          selIdx;
  logic [9:0]          coldPoint;
  logic [9:0]          hotPoint;

  function automatic logic [23:0] gainAddr(input logic [3:0] ent,
                                           input logic [1:0] sub);
    logic [23:0] roomA;
    logic [23:0] adjA;
    if (ent == stl_pkg::BAT_ENTRY) begin
      roomA = stl_pkg::BAT_ROOM_ADDR;
      adjA  = stl_pkg::BAT_ADJ_ADDR;
    end else if (ent == stl_pkg::OPT_ENTRY) begin
      roomA = stl_pkg::OPT_ROOM_ADDR;
      adjA  = stl_pkg::OPT_ADJ_ADDR;
    end else begin
      roomA = stl_pkg::CUR_ROOM_BASE + {19'h0, ent, 1'b0};
      adjA  = stl_pkg::CUR_ADJ_BASE + {19'h0, ent, 1'b0};
    end
    case (sub)
      stl_pkg::SUB_ROOM_HI: gainAddr = roomA;
      stl_pkg::SUB_ROOM_LO: gainAddr = roomA + stl_pkg::ADDR_STEP;
      stl_pkg::SUB_COLD:    gainAddr = adjA;
      default:              gainAddr = adjA + stl_pkg::ADDR_STEP;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Gain read-back through the sign-magnitude decoder
  assign selValid = s.gainSel <= stl_pkg::LAST_ENTRY;
  assign selIdx   = selValid ? s.gainSel : 4'h0;

  stl_adjust coldDec (
    .roomGain  (s.room[selIdx]),
    .adjByte   (s.cold[selIdx]),
    .pointGain (coldPoint)
  );

  stl_adjust hotDec (
    .roomGain  (s.room[selIdx]),
    .adjByte   (s.hot[selIdx]),
    .pointGain (hotPoint)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = s;
    n.wrEn = 1'b0;
    swRestart = 1'b0;
    // Register writes: address and data taken in either order
    if (awvalid && s.awready) begin
      n.awHeld = 1'b1;
      n.awAddr = awaddr;
    end
    if (wvalid && s.wready) begin
      n.wHeld = 1'b1;
      n.wData = wdata[7:0];
      n.wStrb0 = wstrb[0];
    end
    if (bready && s.bvalid) begin
      n.bvalid = 1'b0;
    end
    if (s.awHeld && s.wHeld && !s.bvalid) begin
      n.awHeld = 1'b0;
      n.wHeld = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = stl_pkg::RESP_OKAY;
      case (s.awAddr)
        stl_pkg::REG_CTRL: begin
          swRestart = s.wStrb0 && s.wData[stl_pkg::CTRL_RESTART];
        end
        stl_pkg::REG_GAIN_SEL: begin
          if (s.wStrb0) begin
            n.gainSel = s.wData[3:0];
          end
        end
        stl_pkg::REG_STATUS, stl_pkg::REG_OSC, stl_pkg::REG_GAIN_DATA: begin
        end
        default: begin
          n.bresp = stl_pkg::RESP_SLVERR;
        end
      endcase
    end
    n.awready = !n.awHeld && !n.bvalid;
    n.wready = !n.wHeld && !n.bvalid;
    // Register reads
    if (rready && s.rvalid) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp = stl_pkg::RESP_OKAY;
      n.rdata = 32'h0;
      case (araddr)
        stl_pkg::REG_CTRL: begin
        end
        stl_pkg::REG_STATUS: begin
          n.rdata[0] = s.trimDone;
          n.rdata[1] = s.gainDone;
          n.rdata[2] = s.oscValid;
          n.rdata[3] = s.phase != stl_pkg::PH_DONE;
        end
        stl_pkg::REG_OSC: n.rdata[12:0] = s.oscTrim;
        stl_pkg::REG_GAIN_SEL: n.rdata[3:0] = s.gainSel;
        stl_pkg::REG_GAIN_DATA: begin
          if (selValid) begin
            n.rdata = {2'h0, hotPoint, coldPoint, s.room[selIdx]};
          end
        end
        default: n.rresp = stl_pkg::RESP_SLVERR;
      endcase
    end
    n.arready = !n.rvalid;
    // Loader sequence: one flash byte per request, held until acknowledged
    case (s.phase)
      stl_pkg::PH_TRIM_RD: begin
        if (!s.req) begin
          n.req = 1'b1;
          n.addr = stl_pkg::TRIM_SRC_BASE + {20'h0, s.idx};
        end else if (flashRdAck) begin
          n.req = 1'b0;
          n.wrEn = 1'b1;
          n.wrAddr = stl_pkg::TRIM_DST_BASE + {4'h0, s.idx};
          n.wrData = flashRdData;
          if (s.idx == stl_pkg::OSC_HI_IDX) begin
            n.oscTrim[12:8] = flashRdData[4:0];
          end
          if (s.idx == stl_pkg::OSC_LO_IDX) begin
            n.oscTrim[7:0] = flashRdData;
          end
          n.phase = stl_pkg::PH_TRIM_WR;
        end
      end
      stl_pkg::PH_TRIM_WR: begin
        if (s.idx == stl_pkg::TRIM_LAST_IDX) begin
          n.trimDone = 1'b1;
          n.oscValid = 1'b1;
          n.idx = 4'h0;
          n.sub = stl_pkg::SUB_ROOM_HI;
          n.phase = stl_pkg::PH_GAIN_RD;
        end else begin
          n.idx = s.idx + 4'h1;
          n.phase = stl_pkg::PH_TRIM_RD;
        end
      end
      stl_pkg::PH_GAIN_RD: begin
        if (!s.req) begin
          n.req = 1'b1;
          n.addr = gainAddr(s.idx, s.sub);
        end else if (flashRdAck) begin
          n.req = 1'b0;
          case (s.sub)
            stl_pkg::SUB_ROOM_HI: n.hiBits = flashRdData[1:0];
            stl_pkg::SUB_ROOM_LO: begin
              n.room[s.idx] = {s.hiBits, flashRdData};
            end
            stl_pkg::SUB_COLD: n.cold[s.idx] = flashRdData;
            default: n.hot[s.idx] = flashRdData;
          endcase
          n.sub = s.sub + 2'h1;
          if (s.sub == stl_pkg::SUB_HOT) begin
            if (s.idx == stl_pkg::LAST_ENTRY) begin
              n.gainDone = 1'b1;
              n.phase = stl_pkg::PH_DONE;
            end else begin
              n.idx = s.idx + 4'h1;
            end
          end
        end
      end
      stl_pkg::PH_DONE: begin
      end
      default: n.phase = stl_pkg::PH_DONE;
    endcase
    // Low-power reset or software restart reruns the whole load
    if (restartAny) begin
      n.phase = stl_pkg::PH_TRIM_RD;
      n.idx = 4'h0;
      n.sub = stl_pkg::SUB_ROOM_HI;
      n.req = 1'b0;
      n.wrEn = 1'b0;
      n.trimDone = 1'b0;
      n.gainDone = 1'b0;
      n.oscValid = 1'b0;
    end
  end

  assign restartAny = lowPowerRestart || swRestart;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s <= stl_pkg::STATE_RST;
    end else begin
      s <= n;
    end
  end

  assign flashRdReq       = s.req;
  assign flashAddr        = s.addr;
  assign trimWrEn         = s.wrEn;
  assign trimWrAddr       = s.wrAddr;
  assign trimWrData       = s.wrData;
  assign slowOscTrimField = s.oscTrim;
  assign oscTrimValid     = s.oscValid;
  assign trimDone         = s.trimDone;
  assign gainDone         = s.gainDone;
  assign awready          = s.awready;
  assign wready           = s.wready;
  assign bvalid           = s.bvalid;
  assign bresp            = s.bresp;
  assign arready          = s.arready;
  assign rvalid           = s.rvalid;
  assign rdata            = s.rdata;
  assign rresp            = s.rresp;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  trim_dest_map_a: assert property (
    s.wrEn |-> (s.wrAddr - stl_pkg::TRIM_DST_BASE)
               == (s.addr[7:0] - stl_pkg::TRIM_SRC_BASE[7:0])
  ) else $error("trim byte written to wrong die register");

  trim_copy_data_a: assert property (
    (s.phase == stl_pkg::PH_TRIM_RD && s.req && flashRdAck && !restartAny)
    |=> s.wrEn && s.wrData == $past(flashRdData) ##1 !s.wrEn
  ) else $error("trim byte not copied as read");

  osc_field_a: assert property (
    (s.phase == stl_pkg::PH_TRIM_WR && s.idx == stl_pkg::OSC_LO_IDX
     && !restartAny)
    |=> s.oscValid && s.oscTrim[7:0] == $past(s.wrData)
  ) else $error("oscillator field not valid after its last byte");

  gain_addr_range_a: assert property (
    (s.req && s.phase == stl_pkg::PH_GAIN_RD) |->
      (s.addr >= stl_pkg::CUR_ROOM_BASE && s.addr <= stl_pkg::CUR_ROOM_LAST)
      || (s.addr >= stl_pkg::BAT_ROOM_ADDR && s.addr <= stl_pkg::OPT_ROOM_LAST)
      || (s.addr >= stl_pkg::BAT_ADJ_ADDR && s.addr <= stl_pkg::CUR_ADJ_LAST)
  ) else $error("gain fetch outside the gain area");

  room_pair_a: assert property (
    (s.phase == stl_pkg::PH_GAIN_RD && s.req && flashRdAck
     && s.sub == stl_pkg::SUB_ROOM_LO && !restartAny)
    |=> s.room[$past(s.idx)] == {$past(s.hiBits), $past(flashRdData)}
  ) else $error("room gain pair assembled wrongly");

  cold_sign_a: assert property (
    (selValid && s.cold[selIdx][stl_pkg::SIGN_BIT])
    |-> coldPoint <= s.room[selIdx]
  ) else $error("negative adjustment raised the gain");

  hot_sign_a: assert property (
    (selValid && !s.hot[selIdx][stl_pkg::SIGN_BIT])
    |-> hotPoint >= s.room[selIdx]
  ) else $error("positive adjustment lowered the gain");

  done_order_a: assert property (
    $rose(s.gainDone) |-> s.trimDone && s.oscValid && !s.req
  ) else $error("gain fetch finished before trim copy");

  restart_seq_a: assert property (
    restartAny |=> s.phase == stl_pkg::PH_TRIM_RD && !s.trimDone
                   ##1 s.req && s.addr == stl_pkg::TRIM_SRC_BASE
  ) else $error("restart did not begin at the first trim byte");

  trim_last_a: assert property (
    s.req && s.phase == stl_pkg::PH_TRIM_RD
    |-> s.addr >= stl_pkg::TRIM_SRC_BASE && s.addr <= stl_pkg::TRIM_SRC_LAST
  ) else $error("trim read outside the trim area");
endmodule
`default_nettype wire

// [hdl/stl_pkg.sv]
`default_nettype none
package stl_pkg;
  // Factory information area map
  localparam logic [23:0] TRIM_SRC_BASE = 24'h0180d0;
  localparam logic [23:0] TRIM_SRC_LAST = 24'h0180d9;
  localparam logic [7:0]  TRIM_DST_BASE = 8'he0;
  localparam logic [3:0]  TRIM_LAST_IDX = 4'h9;
  localparam logic [23:0] CUR_ROOM_BASE = 24'h0180c0;
  localparam logic [23:0] CUR_ROOM_LAST = 24'h0180cf;
  localparam logic [23:0] BAT_ROOM_ADDR = 24'h0180de;
  localparam logic [23:0] OPT_ROOM_LAST = 24'h0180e1;
  localparam logic [23:0] OPT_ROOM_ADDR = 24'h0180e0;
  localparam logic [23:0] BAT_ADJ_ADDR  = 24'h0180ec;
  localparam logic [23:0] OPT_ADJ_ADDR  = 24'h0180ee;
  localparam logic [23:0] CUR_ADJ_BASE  = 24'h0180f0;
  localparam logic [23:0] CUR_ADJ_LAST  = 24'h0180ff;
  localparam logic [23:0] ADDR_STEP     = 24'h000001;
  // Gain table entries: 0..7 current ranges 4..512, then the two voltages
  localparam int          GAIN_ENTRIES  = 10;
  localparam logic [3:0]  BAT_ENTRY     = 4'h8;
  localparam logic [3:0]  OPT_ENTRY     = 4'h9;
  localparam logic [3:0]  LAST_ENTRY    = 4'h9;
  localparam logic [1:0]  SUB_ROOM_HI   = 2'h0;
  localparam logic [1:0]  SUB_ROOM_LO   = 2'h1;
  localparam logic [1:0]  SUB_COLD      = 2'h2;
  localparam logic [1:0]  SUB_HOT       = 2'h3;
  localparam int          SIGN_BIT      = 7;
  localparam logic [9:0]  GAIN_MAX      = 10'h3ff;
  localparam logic [9:0]  GAIN_MIN      = 10'h000;
  // Trim bytes that carry the 13-bit slow oscillator field
  localparam logic [3:0]  OSC_HI_IDX    = 4'h8;
  localparam logic [3:0]  OSC_LO_IDX    = 4'h9;
  // Register map (byte addresses)
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_OSC       = 8'h08;
  localparam logic [7:0]  REG_GAIN_SEL  = 8'h0c;
  localparam logic [7:0]  REG_GAIN_DATA = 8'h10;
  localparam int          CTRL_RESTART  = 0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    PH_TRIM_RD,
    PH_TRIM_WR,
    PH_GAIN_RD,
    PH_DONE
  } stl_phase_t;

  typedef struct packed {
    stl_phase_t                   phase;
    logic [3:0]                   idx;
    logic [1:0]                   sub;
    logic                         req;
    logic [23:0]                  addr;
    logic                         wrEn;
    logic [7:0]                   wrAddr;
    logic [7:0]                   wrData;
    logic [12:0]                  oscTrim;
    logic                         oscValid;
    logic                         trimDone;
    logic                         gainDone;
    logic [1:0]                   hiBits;
    logic [GAIN_ENTRIES-1:0][9:0] room;
    logic [GAIN_ENTRIES-1:0][7:0] cold;
    logic [GAIN_ENTRIES-1:0][7:0] hot;
    logic [3:0]                   gainSel;
    logic                         awHeld;
    logic [7:0]                   awAddr;
    logic                         wHeld;
    logic [7:0]                   wData;
    logic                         wStrb0;
    logic                         awready;
    logic                         wready;
    logic                         bvalid;
    logic [1:0]                   bresp;
    logic                         arready;
    logic                         rvalid;
    logic [1:0]                   rresp;
    logic [31:0]                  rdata;
  } stl_state_t;

  localparam stl_state_t STATE_RST = '0;
endpackage
`default_nettype wire

// [hdl/stl_adjust.sv]
`default_nettype none
// Applies a sign-magnitude adjustment byte to a room gain, saturating
module stl_adjust (
  input  wire logic [9:0] roomGain,
  input  wire logic [7:0] adjByte,
  output logic      [9:0] pointGain
);
  logic [10:0] sum;
  logic [10:0] mag;

  always_comb begin
    mag = {4'h0, adjByte[stl_pkg::SIGN_BIT-1:0]};
    if (adjByte[stl_pkg::SIGN_BIT]) begin
      sum = {1'b0, roomGain} - mag;
      pointGain = sum[10] ? stl_pkg::GAIN_MIN : sum[9:0];
    end else begin
      sum = {1'b0, roomGain} + mag;
      pointGain = sum[10] ? stl_pkg::GAIN_MAX : sum[9:0];
    end
  end
endmodule
`default_nettype wire

// [verification/stl_flash_model.sv]
`default_nettype none
module stl_flash_model (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        slow,
  input  wire logic        rdReq,
  input  wire logic [23:0] rdAddr,
  output logic             rdAck,
  output logic      [7:0]  rdData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [64];
  logic [1:0] waitCnt;
  //////////////////////////////////////////////////////////////////////////
  // Factory image 0x0180c0..0x0180ff, with two gains set to saturate
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 8'(i * 37 + 11);
    end
    mem[0] = 8'h00;
    mem[1] = 8'h02;
    mem[8'h30] = 8'h85;
    mem[2] = 8'hff;
    mem[3] = 8'hfe;
    mem[8'h33] = 8'h7f;
  end
  //////////////////////////////////////////////////////////////////////////
  // One ack pulse per request, delayed in slow mode; the idle bus toggles
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdAck <= 1'b0;
      rdData <= 8'h00;
      waitCnt <= 2'h0;
    end else begin
      rdAck <= 1'b0;
      rdData <= ~rdData;
      if (!rdReq || rdAck) begin
        waitCnt <= 2'h0;
      end else if (waitCnt < (slow ? 2'h3 : 2'h0)) begin
        waitCnt <= waitCnt + 2'h1;
      end else if (rdAddr[23:6] == 18'h00603) begin
        rdAck <= 1'b1;
        rdData <= mem[rdAddr[5:0]];
      end
    end
  end
endmodule
`default_nettype wire

// [verification/testbench.sv]
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        lowPowerRestart = 1'b0;
  logic        slow = 1'b0;
  logic        flashRdReq, flashRdAck, trimWrEn, oscTrimValid;
  logic        trimDone, gainDone, awready, wready, bvalid, arready, rvalid;
  logic [23:0] flashAddr;
  logic [7:0]  flashRdData, trimWrAddr, trimWrData;
  logic [12:0] slowOscTrimField;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          errors = 0;
  int          num_checks = 0;
  logic [7:0]  dieReg [16];
  logic [7:0]  wrLog [$];
  logic [23:0] rdLog [$];

  stl_loader stl_loader_i (.clock(clock), .nrst(nrst),
    .lowPowerRestart(lowPowerRestart), .flashRdReq(flashRdReq),
    .flashAddr(flashAddr), .flashRdAck(flashRdAck),
    .flashRdData(flashRdData), .trimWrEn(trimWrEn),
    .trimWrAddr(trimWrAddr), .trimWrData(trimWrData),
    .slowOscTrimField(slowOscTrimField), .oscTrimValid(oscTrimValid),
    .trimDone(trimDone), .gainDone(gainDone), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  stl_flash_model stl_flash_model_i (.clock(clock), .nrst(nrst),
    .slow(slow), .rdReq(flashRdReq), .rdAddr(flashAddr),
    .rdAck(flashRdAck), .rdData(flashRdData));

  always #5 clock = ~clock;
  // Analog die register file and transfer logs
  always @(posedge clock) begin
    if (trimWrEn === 1'b1) begin
      wrLog.push_back(trimWrAddr);
      dieReg[trimWrAddr[3:0]] <= trimWrData;
    end
    if (flashRdReq === 1'b1 && flashRdAck === 1'b1) begin
      rdLog.push_back(flashAddr);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wait_done(input bit gain);
    logic flag;
    flag = gain ? gainDone : trimDone;
    for (int n = 0; n < 5000 && flag !== 1'b1; n++) begin
      @(posedge clock);
      flag = gain ? gainDone : trimDone;
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] resp);
    bit awP, wP, done;
    awP = 1;
    wP = 1;
    done = 0;
    resp = 2'h1;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1'b1;
    for (int n = 0; n < 200 && !done; n++) begin
      @(posedge clock);
      if (awP && awready === 1'b1) begin
        awP = 0;
        awvalid <= 1'b0;
      end
      if (wP && wready === 1'b1) begin
        wP = 0;
        wvalid <= 1'b0;
      end
      if (!awP && !wP && bvalid === 1'b1) begin
        done = 1;
        resp = bresp;
        bready <= 1'b0;
      end
    end
    if (!done) errors++;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
    bit arP, done;
    arP = 1;
    done = 0;
    d = 32'hx;
    resp = 2'h1;
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (int n = 0; n < 200 && !done; n++) begin
      @(posedge clock);
      if (arP && arready === 1'b1) begin
        arP = 0;
        arvalid <= 1'b0;
      end else if (!arP && rvalid === 1'b1) begin
        done = 1;
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
      end
    end
    if (!done) errors++;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] gaddr(int e, int k);
    logic [5:0] room, adj;
    room = (e < 8) ? 6'(2 * e) : (e == 8) ? 6'h1e : 6'h20;
    adj = (e < 8) ? 6'(8'h30 + 2 * e) : (e == 8) ? 6'h2c : 6'h2e;
    return (k < 2) ? room + 6'(k) : adj + 6'(k - 2);
  endfunction

  function automatic logic [9:0] pt(logic [9:0] r, logic [7:0] a);
    logic [10:0] s;
    if (a[7]) s = ({4'h0, a[6:0]} > {1'b0, r}) ? 11'h0 : r - a[6:0];
    else s = ({1'b0, r} + a[6:0] > 11'h3ff) ? 11'h3ff : r + a[6:0];
    return s[9:0];
  endfunction

  task automatic test_trim();
    logic [31:0] d;
    logic [1:0]  r;
    int          t;
    wait_done(0);
    check("trimDone", trimDone, 1);
    check("trim write count", wrLog.size() >= 10, 1);
    t = wrLog.size() - 10;
    for (int i = 0; i < 10; i++) begin
      check("trim addr", wrLog[t + i], 8'he0 + 8'(i));
      check("trim byte", dieReg[i], stl_flash_model_i.mem[16 + i]);
    end
    check("osc field", slowOscTrimField, {stl_flash_model_i.mem[24][4:0],
          stl_flash_model_i.mem[25]});
    check("osc valid", oscTrimValid, 1);
    axi_read(stl_pkg::REG_OSC, d, r);
    check("osc reg", d, {19'h0, stl_flash_model_i.mem[24][4:0],
          stl_flash_model_i.mem[25]});
  endtask

  task automatic test_gain();
    logic [31:0] d;
    logic [1:0]  r;
    logic [9:0]  room;
    int          t;
    wait_done(1);
    check("gainDone", gainDone, 1);
    t = rdLog.size() - 50;
    for (int j = 0; j < 50; j++) begin
      check("flash addr", rdLog[t + j], 24'h0180c0 + ((j < 10) ? 6'(16 + j) :
            gaddr((j - 10) / 4, (j - 10) % 4)));
    end
    for (int e = 0; e < 11; e++) begin
      axi_write(stl_pkg::REG_GAIN_SEL, e, r);
      check("sel resp", r, stl_pkg::RESP_OKAY);
      axi_read(stl_pkg::REG_GAIN_SEL, d, r);
      check("sel readback", d, e);
      axi_read(stl_pkg::REG_GAIN_DATA, d, r);
      room = {stl_flash_model_i.mem[gaddr(e, 0)][1:0],
              stl_flash_model_i.mem[gaddr(e, 1)]};
      check("gain points", d, (e > 9) ? 32'h0 : {2'b0,
            pt(room, stl_flash_model_i.mem[gaddr(e, 3)]),
            pt(room, stl_flash_model_i.mem[gaddr(e, 2)]),
            room});
    end
    axi_read(stl_pkg::REG_STATUS, d, r);
    check("status", d, 32'h7);
    axi_read(8'h14, d, r);
    check("unmapped read data", d, 32'h0);
    check("unmapped read resp", r, stl_pkg::RESP_SLVERR);
    axi_write(8'h14, 32'h1, r);
    check("unmapped write", r, stl_pkg::RESP_SLVERR);
  endtask

  task automatic test_restart();
    logic [1:0] r;
    int         n0;
    slow <= 1'b1;
    lowPowerRestart <= 1'b1;
    @(posedge clock);
    lowPowerRestart <= 1'b0;
    repeat (2) @(posedge clock);
    check("flags cleared", {trimDone, gainDone}, 2'b00);
    n0 = wrLog.size();
    for (int n = 0; n < 2000 && wrLog.size() < n0 + 4; n++) begin
      @(posedge clock);
    end
    // Software restart in the middle of the trim copy
    axi_write(stl_pkg::REG_CTRL, 32'h1, r);
    check("ctrl resp", r, stl_pkg::RESP_OKAY);
    check("trim restarted", trimDone, 0);
    n0 = wrLog.size();
    test_trim();
    check("restart first", wrLog[n0], 8'he0);
    test_gain();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    test_trim();
    test_gain();
    test_restart();
    complete_run();
  end

  initial begin
    #300000;
    errors++;
    complete_run();
  end
endmodule
`default_nettype wire
